// >>> rtl/ivf_regs.vh
// command codes, field positions, reset values and states for the input voltage fault block
`ifndef IVF_REGS_VH
`define IVF_REGS_VH

// command codes
`define IVF_CMD_OV_FAULT_THR 8'h55
`define IVF_CMD_OV_FAULT_ACT 8'h56
`define IVF_CMD_OV_WARN_THR 8'h57
`define IVF_CMD_UV_WARN_THR 8'h58

// action byte fields
`define IVF_RESP_HI 7
`define IVF_RESP_LO 6
`define IVF_RETRY_HI 5
`define IVF_RETRY_LO 3
`define IVF_TIME_HI 2
`define IVF_TIME_LO 0

// response codes
`define IVF_RESP_IGNORE 2'h0
`define IVF_RESP_DELAY 2'h1
`define IVF_RESP_RETRY 2'h2
`define IVF_RESP_LATCH 2'h3

// retry codes
`define IVF_RETRY_NONE 3'h0
`define IVF_RETRY_FOREVER 3'h7

// linear format layout
`define IVF_EXP_HI 15
`define IVF_EXP_LO 11
`define IVF_MANT_HI 10
`define IVF_EXP_BIAS 16
`define IVF_LIN_W 43

// reset values
`define IVF_RST_OV_FAULT_THR 16'h0000
`define IVF_RST_OV_FAULT_ACT 8'h00
`define IVF_RST_OV_WARN_THR 16'h0000
`define IVF_RST_UV_WARN_THR 16'h0000

// one-hot states
`define IVF_ST_RUN 4'h1
`define IVF_ST_DELAY 4'h2
`define IVF_ST_WAIT 4'h4
`define IVF_ST_LATCH 4'h8

`endif

// >>> rtl/ivf_input_voltage_fault_response.v
// input over-voltage fault response, warning thresholds and command port
`timescale 1ns/1ps
`default_nettype none
`include "ivf_regs.vh"

// What this block does
// - holds a 16-bit over-voltage fault threshold, writable and readable.
// - response 00 keeps running without interruption on a fault.
// - response 01 runs for the delay, then applies retry setting if fault persists.
// - response 10 disables output at once, then applies retry setting.
// - response 11 latches off until status clear, clear-faults, reset or off-on.
// - retry code 000 means no restart; output stays off until cleared.
// - retry codes 1..6 try that many restarts, then latch off.
// - restart attempts are spaced by the retry time in delay units.
// - retry code 111 retries forever until commanded off or another fault.
// - retry time field n decodes to 2 to the n delay units.
// - the same decoded delay serves response 01 and restart spacing.
// - holds a 16-bit over-voltage warning threshold, writable and readable.
// - under-voltage warning threshold also sets the ratio regulation threshold.
module ivf_input_voltage_fault_response (
	// clock and reset
	input wire clock,
	input wire srst,
	// command port
	input wire cmd_wr,
	input wire cmd_rd,
	input wire [7:0] cmd_code,
	input wire [15:0] cmd_wdata,
	output reg [15:0] cmd_rdata_q,
	output reg cmd_rvalid_q,
	output reg cmd_unsupported_q,
	// measurement and timing
	input wire [15:0] vin_meas,
	input wire unit_tick,
	// fault clearing and control
	input wire status_clear,
	input wire clear_faults,
	input wire ctrl_on,
	input wire other_fault,
	input wire vendor_option_command,
	// outputs
	output reg output_enable_q,
	output reg ov_fault_q,
	output reg ov_warn_q,
	output reg uv_warn_q,
	output reg ratio_regulation_mode_q,
	output reg [15:0] ratio_threshold_q
);

	// linear format to a common fixed-point scale so values with different exponents compare
	function signed [`IVF_LIN_W-1:0] lin_value;
		input [15:0] v;
		integer sh;
		begin
			sh = $signed(v[`IVF_EXP_HI:`IVF_EXP_LO]) + `IVF_EXP_BIAS;
			lin_value = $signed({{(`IVF_LIN_W-`IVF_MANT_HI-1){v[`IVF_MANT_HI]}}, v[`IVF_MANT_HI:0]}) <<< sh;
		end
	endfunction

	reg [15:0] ov_fault_thr_q;
	reg [7:0] ov_fault_act_q;
	reg [15:0] ov_warn_thr_q;
	reg [15:0] uv_warn_thr_q;
	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [7:0] timer_q;
	reg [7:0] timer_d;
	reg [2:0] tries_q;
	reg [2:0] tries_d;
	reg ctrl_on_q;
	reg latch_set;

	wire [1:0] resp = ov_fault_act_q[`IVF_RESP_HI:`IVF_RESP_LO];
	wire [2:0] retries = ov_fault_act_q[`IVF_RETRY_HI:`IVF_RETRY_LO];
	wire [2:0] rtime = ov_fault_act_q[`IVF_TIME_HI:`IVF_TIME_LO];
	wire [7:0] delay_units = 8'h01 << rtime;
	wire signed [`IVF_LIN_W-1:0] vin_lin = lin_value(vin_meas);
	wire ov_cond = vin_lin > lin_value(ov_fault_thr_q);
	wire ov_warn_cond = vin_lin > lin_value(ov_warn_thr_q);
	wire uv_warn_cond = vin_lin < lin_value(uv_warn_thr_q);
	wire timer_done = (timer_q == 8'h00);
	wire ctrl_off_edge = ctrl_on_q & ~ctrl_on;
	wire fault_clear = status_clear | clear_faults | ctrl_off_edge;

	// command writes; the action register is one byte, upper data bits dropped
	always @(posedge clock) begin
		if (srst) begin
			ov_fault_thr_q <= `IVF_RST_OV_FAULT_THR;
			ov_fault_act_q <= `IVF_RST_OV_FAULT_ACT;
			ov_warn_thr_q <= `IVF_RST_OV_WARN_THR;
			uv_warn_thr_q <= `IVF_RST_UV_WARN_THR;
		end else if (cmd_wr) begin
			case (cmd_code)
				`IVF_CMD_OV_FAULT_THR: ov_fault_thr_q <= cmd_wdata;
				`IVF_CMD_OV_FAULT_ACT: ov_fault_act_q <= cmd_wdata[7:0];
				`IVF_CMD_OV_WARN_THR: ov_warn_thr_q <= cmd_wdata;
				`IVF_CMD_UV_WARN_THR: uv_warn_thr_q <= cmd_wdata;
				default: ov_fault_thr_q <= ov_fault_thr_q;
			endcase
		end
	end

	// command reads answer one cycle later; unknown codes flag unsupported
	always @(posedge clock) begin
		if (srst) begin
			cmd_rdata_q <= 16'h0000;
			cmd_rvalid_q <= 1'b0;
			cmd_unsupported_q <= 1'b0;
		end else begin
			cmd_rvalid_q <= cmd_rd;
			cmd_unsupported_q <= 1'b0;
			if (cmd_rd) begin
				case (cmd_code)
					`IVF_CMD_OV_FAULT_THR: cmd_rdata_q <= ov_fault_thr_q;
					`IVF_CMD_OV_FAULT_ACT: cmd_rdata_q <= {8'h00, ov_fault_act_q};
					`IVF_CMD_OV_WARN_THR: cmd_rdata_q <= ov_warn_thr_q;
					`IVF_CMD_UV_WARN_THR: cmd_rdata_q <= uv_warn_thr_q;
					default: begin
						cmd_rdata_q <= 16'h0000;
						cmd_unsupported_q <= 1'b1;
					end
				endcase
			end
		end
	end

	// response sequencer
	always @* begin
		state_d = state_q;
		timer_d = (unit_tick && !timer_done) ? timer_q - 8'h01 : timer_q;
		tries_d = tries_q;
		latch_set = 1'b0;
		case (state_q)
			`IVF_ST_RUN: begin
				if (ctrl_on && ov_cond) begin
					case (resp)
						`IVF_RESP_IGNORE: state_d = `IVF_ST_RUN;
						`IVF_RESP_DELAY: begin
							state_d = `IVF_ST_DELAY;
							timer_d = delay_units;
						end
						`IVF_RESP_RETRY: latch_set = 1'b1;
						default: state_d = `IVF_ST_LATCH;
					endcase
				end
			end
			`IVF_ST_DELAY: begin
				// still running; decide only when the delay has run out
				if (timer_done) begin
					if (ov_cond)
						latch_set = 1'b1;
					else
						state_d = `IVF_ST_RUN;
				end
			end
			`IVF_ST_WAIT: begin
				if (other_fault) begin
					state_d = `IVF_ST_LATCH;
				end else if (timer_done) begin
					if (!ov_cond) begin
						state_d = `IVF_ST_RUN;
					end else if (retries == `IVF_RETRY_FOREVER) begin
						timer_d = delay_units;
					end else if (tries_q == 3'h1) begin
						state_d = `IVF_ST_LATCH;
					end else begin
						tries_d = tries_q - 3'h1;
						timer_d = delay_units;
					end
				end
			end
			`IVF_ST_LATCH: begin
				if (fault_clear)
					state_d = `IVF_ST_RUN;
			end
			default: state_d = `IVF_ST_RUN;
		endcase
		// output disabled: go by the retry setting
		if (latch_set) begin
			if (retries == `IVF_RETRY_NONE) begin
				state_d = `IVF_ST_LATCH;
			end else begin
				state_d = `IVF_ST_WAIT;
				tries_d = retries;
				timer_d = delay_units;
			end
		end
		// commanded off stops every retry and clears a latch
		if (!ctrl_on)
			state_d = `IVF_ST_RUN;
	end

	// state, timer and output registers
	always @(posedge clock) begin
		if (srst) begin
			state_q <= `IVF_ST_RUN;
			timer_q <= 8'h00;
			tries_q <= 3'h0;
			ctrl_on_q <= 1'b0;
			output_enable_q <= 1'b0;
			ov_fault_q <= 1'b0;
			ov_warn_q <= 1'b0;
			uv_warn_q <= 1'b0;
			ratio_regulation_mode_q <= 1'b0;
			ratio_threshold_q <= `IVF_RST_UV_WARN_THR;
		end else begin
			state_q <= state_d;
			timer_q <= timer_d;
			tries_q <= tries_d;
			ctrl_on_q <= ctrl_on;
			// output runs only in run or delay states
			output_enable_q <= ctrl_on && (state_d == `IVF_ST_RUN || state_d == `IVF_ST_DELAY);
			// a new detection beats a clear in the same cycle
			if (ov_cond)
				ov_fault_q <= 1'b1;
			else if (fault_clear)
				ov_fault_q <= 1'b0;
			ov_warn_q <= ov_warn_cond;
			uv_warn_q <= uv_warn_cond;
			ratio_regulation_mode_q <= vendor_option_command;
			ratio_threshold_q <= uv_warn_thr_q;
		end
	end

endmodule // ivf_input_voltage_fault_response
`default_nettype wire

// >>> bench/ivf_checks_properties.sv
// port checks for the input voltage fault block
`timescale 1ns/1ps
`default_nettype none
module ivf_checks (
	// clock and reset
	input wire logic clock,
	input wire logic srst,
	// command port
	input wire logic cmd_wr,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	input wire logic [15:0] cmd_rdata_q,
	input wire logic cmd_unsupported_q,
	// control and status
	input wire logic status_clear,
	input wire logic clear_faults,
	input wire logic ctrl_on,
	input wire logic output_enable_q,
	input wire logic ov_fault_q,
	input wire logic [15:0] ratio_threshold_q
);
	logic [7:0] act_q;
	wire hold_off;
	// mirror of the action byte, the only state these checks need
	always @(posedge clock) begin
		if (srst)
			act_q <= 8'h00;
		else if (cmd_wr && cmd_code == 8'h56)
			act_q <= cmd_wdata[7:0];
	end
	// settings that leave the output off until a clear
	assign hold_off = act_q[7:6] == 2'h3 || act_q[7:6] != 2'h0 && act_q[5:3] == 3'h0;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	a_unknown_read: assert property (cmd_rd && cmd_code > 8'h58 |=> cmd_unsupported_q && cmd_rdata_q == 16'h0000)
		else $error("unknown read not refused");
	a_action_read: assert property (cmd_rd && cmd_code == 8'h56 |=> cmd_rdata_q == {8'h00, act_q})
		else $error("action byte read back wrong");
	a_ignore_on: assert property (act_q[7:6] == 2'h0 && output_enable_q && ctrl_on |=> output_enable_q)
		else $error("ignored fault cut output");
	a_off_at_once: assert property ($rose(ov_fault_q) && $past(output_enable_q) && act_q[7] |-> !output_enable_q)
		else $error("output not cut on fault");
	a_delay_on: assert property ($rose(ov_fault_q) && $past(output_enable_q) && act_q[7:6] == 2'h1 |-> output_enable_q)
		else $error("output cut before delay");
	// ctrl_on high now and two samples back keeps the output start-up lag out of the antecedent
	a_latch_holds: assert property (!output_enable_q && hold_off && ov_fault_q && ctrl_on && $past(ctrl_on, 2)
		&& !status_clear && !clear_faults |=> !output_enable_q) else $error("latched output restarted");
	a_off_follows: assert property (!ctrl_on |=> !output_enable_q)
		else $error("output on while commanded off");
	a_ratio_copy: assert property (cmd_wr && cmd_code == 8'h58 |-> ##2 ratio_threshold_q == $past(cmd_wdata, 2))
		else $error("ratio threshold not copied");
	c_cut: cover property ($fell(output_enable_q));
	c_clear: cover property (status_clear && !output_enable_q);
	c_unknown: cover property (cmd_unsupported_q);
endmodule // ivf_checks
bind ivf_input_voltage_fault_response ivf_checks u_checks (.clock(clock), .srst(srst), .cmd_wr(cmd_wr),
	.cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata_q(cmd_rdata_q),
	.cmd_unsupported_q(cmd_unsupported_q), .status_clear(status_clear), .clear_faults(clear_faults),
	.ctrl_on(ctrl_on), .output_enable_q(output_enable_q), .ov_fault_q(ov_fault_q),
	.ratio_threshold_q(ratio_threshold_q));
`default_nettype wire

// >>> bench/ivf_host_model.sv
// host model issuing command strobes
`timescale 1ns/1ps
`default_nettype none
module ivf_host_model (
	// command port toward the device
	input wire logic clock,
	output logic wr = 1'h0,
	output logic rd = 1'h0,
	output logic [7:0] code = 8'h00,
	output logic [15:0] wdata = 16'h0000
);
	// one-cycle strobe; idle values are scrambled so stale data never looks valid
	task put(input [7:0] c, input [15:0] d, input w);
		begin
			@(negedge clock);
			code = c;
			wdata = d;
			wr = w;
			rd = !w;
			@(negedge clock);
			wr = 1'h0;
			rd = 1'h0;
			code = ~c;
			wdata = ~d;
		end
	endtask
endmodule // ivf_host_model
`default_nettype wire

// >>> bench/ivf_input_voltage_fault_response_test.sv
// self-checking bench for the input voltage fault block
`timescale 1ns/1ps
`default_nettype none
module ivf_input_voltage_fault_response_test;
	logic clock = 1'h0, srst = 1'h1, tick = 1'h0, sclr = 1'h0, cf = 1'h0, con = 1'h0, vopt = 1'h0, ofl = 1'h0;
	logic [15:0] vin = 16'h0070;
	wire wr, rd, oe, ovf, ovw, uvw, rrm, rv, uns;
	wire [7:0] code;
	wire [15:0] wd, rdat, rthr;
	integer miscompares = 0, check_count = 0, cyc = 0, i;
	always #20 clock = ~clock;
	ivf_host_model host (.clock(clock), .wr(wr), .rd(rd), .code(code), .wdata(wd));
	ivf_input_voltage_fault_response dut (.clock(clock), .srst(srst), .cmd_wr(wr), .cmd_rd(rd), .cmd_code(code),
		.cmd_wdata(wd), .cmd_rdata_q(rdat), .cmd_rvalid_q(rv), .cmd_unsupported_q(uns), .vin_meas(vin), .unit_tick(tick),
		.status_clear(sclr), .clear_faults(cf), .ctrl_on(con), .other_fault(ofl), .vendor_option_command(vopt),
		.output_enable_q(oe), .ov_fault_q(ovf), .ov_warn_q(ovw), .uv_warn_q(uvw), .ratio_regulation_mode_q(rrm),
		.ratio_threshold_q(rthr));
	task chk(input [15:0] s, input [15:0] e);
		begin
			check_count = check_count + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("CHECK FAILED at %0t: saw %h expected %h", $time, s, e);
			end
		end
	endtask
	task conclude;
		begin
			$display("checks %0d mismatches %0d", check_count, miscompares);
			if (miscompares == 0 && check_count > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	// set the input, send k time units, let the sequencer settle, then look at the output
	task go(input [15:0] v, input integer k, input e);
		begin
			vin = v;
			repeat (k) begin
				@(negedge clock) tick = 1'h1;
				@(negedge clock) tick = 1'h0;
			end
			repeat (3) @(negedge clock);
			chk({15'h0000, oe}, {15'h0000, e});
		end
	endtask
	task clr;
		begin
			sclr = 1'h1;
			@(negedge clock);
			sclr = 1'h0;
		end
	endtask
	// hang guard, far above the few hundred cycles the run needs
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			conclude;
		end
	end
	initial begin
		repeat (16) @(negedge clock);
		srst = 1'h0;
		// reset value, write and read back; 0x59 is unmapped
		for (i = 8'h55; i <= 8'h59; i = i + 1) begin
			host.put(i[7:0], 16'h0000, 1'h0);
			chk(rdat, 16'h0000);
			chk({14'h0000, rv, uns}, {14'h0000, 1'h1, i == 8'h59});
			host.put(i[7:0], 16'hA5C3, 1'h1);
			host.put(i[7:0], 16'h0000, 1'h0);
			chk(rdat, i == 8'h56 ? 16'h00C3 : i == 8'h59 ? 16'h0000 : 16'hA5C3);
			chk({14'h0000, rv, uns}, {14'h0000, 1'h1, i == 8'h59});
		end
		host.put(8'h55, 16'h0080, 1'h1);
		host.put(8'h57, 16'h0064, 1'h1);
		host.put(8'h58, 16'h0050, 1'h1);
		vopt = 1'h1;
		con = 1'h1;
		host.put(8'h56, 16'h0000, 1'h1);
		chk(rthr, 16'h0050);
		chk({15'h0000, rrm}, 16'h0001);
		chk({14'h0000, ovw, uvw}, 16'h0002);
		go(16'h0040, 0, 1'h1);
		chk({14'h0000, ovw, uvw}, 16'h0001);
		go(16'h0090, 0, 1'h1);
		chk({15'h0000, ovf}, 16'h0001);
		go(16'h0070, 0, 1'h1);
		clr;
		// keep running two units, then latch off with no retry
		host.put(8'h56, 16'h0041, 1'h1);
		go(16'h0090, 1, 1'h1);
		go(16'h0090, 1, 1'h0);
		go(16'h0070, 4, 1'h0);
		clr;
		go(16'h0070, 0, 1'h1);
		// two retries four units apart: first fails, second succeeds
		host.put(8'h56, 16'h0092, 1'h1);
		go(16'h0090, 0, 1'h0);
		go(16'h0090, 4, 1'h0);
		go(16'h0070, 3, 1'h0);
		go(16'h0070, 1, 1'h1);
		clr;
		// one retry that fails leaves the output off until clear-faults
		host.put(8'h56, 16'h008A, 1'h1);
		go(16'h0090, 4, 1'h0);
		go(16'h0070, 8, 1'h0);
		cf = 1'h1;
		@(negedge clock);
		cf = 1'h0;
		go(16'h0070, 0, 1'h1);
		clr;
		host.put(8'h56, 16'h00B8, 1'h1);
		go(16'h0090, 20, 1'h0);
		go(16'h0070, 1, 1'h1);
		// another fault during endless retries latches the output off
		go(16'h0090, 0, 1'h0);
		ofl = 1'h1;
		go(16'h0070, 2, 1'h0);
		ofl = 1'h0;
		go(16'h0070, 2, 1'h0);
		clr;
		// latch off, released by an off-then-on request
		host.put(8'h56, 16'h00C0, 1'h1);
		go(16'h0090, 0, 1'h0);
		go(16'h0070, 5, 1'h0);
		con = 1'h0;
		@(negedge clock);
		con = 1'h1;
		go(16'h0070, 0, 1'h1);
		conclude;
	end
endmodule // ivf_input_voltage_fault_response_test
`default_nettype wire
